/* File: tb_timer_pwm_channels.sv */
// Purpose: Register-level tests of the timer through its strobe port.
// Assumes: Register map and field positions of tpc_regs.svh.
// Notes:   PWM runs with period 10 so waveforms are checked in full.
`timescale 1ns/1ps
`include "tpc_regs.svh"
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("BAD %0t got %h want %h", $time, g, e); \
    end \
  end

module tb_timer_pwm_channels;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic brk = 1'b0;
  logic ext_run = 1'b0;
  logic bce = 1'b0;
  tpc_pkg::tpc_byte_t rdata, r1, r2;
  logic ext_pin, force_in, irq;
  logic [5:0] pin_in, pin_out, pin_oe;
  logic [7:0] h, r;
  int errors = 0;
  int check_count = 0;
  always #4 clk = !clk;
  tpc_timer dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .break_active(brk), .break_clear_enable(bce),
    .ext_timer_clock_pin(ext_pin), .ext_clk_pin_force_in(force_in),
    .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe),
    .irq(irq));
  tpc_pin_model u_pins (.clk_run(ext_run), .far_level(6'h00),
    .ch_pin_out(pin_out), .ch_pin_oe(pin_oe),
    .ext_timer_clock_pin(ext_pin), .ch_pin_in(pin_in));
  // ==========================================================================
  // Bus and measurement tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output tpc_pkg::tpc_byte_t d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    tpc_pkg::tpc_byte_t d;
    rd(a, d);
    `CHK(d, e)
  endtask : rdc
  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h01, v[7:0]);
  endtask : w16
  // High cycles and rising edges of channel 0 over three periods.
  task automatic scan();
    logic p;
    repeat (25) @(posedge clk);
    @(negedge clk) p = pin_out[0];
    h = 8'h00;
    r = 8'h00;
    repeat (30) begin
      @(negedge clk);
      h = h + 8'(pin_out[0]);
      r = r + 8'(pin_out[0] & !p);
      p = pin_out[0];
    end
  endtask : scan
  task automatic complete_run();
    $display("Mismatches %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  // ==========================================================================
  // Tests
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`TPC_OFF_STATUS, `TPC_ST_RESET);
    rdc(`TPC_OFF_MOD_HI, 8'hFF);
    rdc(`TPC_OFF_CNT_LO, 8'h00);
    rdc(`TPC_OFF_BRK_CTL, 8'h00);
    for (int p = 0; p < 7; p++) begin
      wr(`TPC_OFF_STATUS, 8'h10 | 8'(p));
      repeat (128) @(posedge clk);
      wr(`TPC_OFF_STATUS, 8'h20 | 8'(p));
      rd(`TPC_OFF_CNT_LO, r1);
      `CHK(r1 >= 8'(120 >> p) && r1 <= 8'(136 >> p), 1'b1)
    end
    wr(`TPC_OFF_STATUS, 8'h30);
    rdc(`TPC_OFF_CNT_LO, 8'h00);
    rdc(`TPC_OFF_STATUS, 8'h20);
    wr(`TPC_OFF_STATUS, 8'h00);
    repeat (5) @(posedge clk);
    brk <= 1'b1;
    rd(`TPC_OFF_CNT_LO, r1);
    repeat (6) @(posedge clk);
    rd(`TPC_OFF_CNT_LO, r2);
    `CHK(r2, r1)
    brk <= 1'b0;
    wait_mode <= 1'b1;
    rdc(`TPC_OFF_STATUS, 8'h00);
    wr(`TPC_OFF_STATUS, 8'h07);
    wait_mode <= 1'b0;
    rd(`TPC_OFF_CNT_LO, r2);
    `CHK(r2 != r1, 1'b1)
    rdc(`TPC_OFF_STATUS, 8'h00);
    rd(`TPC_OFF_CNT_LO, r1);
    stop_mode <= 1'b1;
    repeat (20) @(posedge clk);
    stop_mode <= 1'b0;
    rd(`TPC_OFF_CNT_LO, r2);
    `CHK(8'(r2 - r1) <= 8'd6, 1'b1)
    wr(`TPC_OFF_STATUS, 8'h37);
    `CHK(force_in, 1'b1)
    wr(`TPC_OFF_STATUS, 8'h07);
    rd(`TPC_OFF_CNT_LO, r1);
    repeat (20) @(posedge clk);
    rd(`TPC_OFF_CNT_LO, r2);
    `CHK(r2, r1)
    ext_run <= 1'b1;
    repeat (200) @(posedge clk);
    rd(`TPC_OFF_CNT_LO, r2);
    `CHK(r2 != r1, 1'b1)
    ext_run <= 1'b0;
    // Halt, clear, period, width, channel, release.
    wr(`TPC_OFF_STATUS, 8'h30);
    `CHK(force_in, 1'b0)
    w16(`TPC_OFF_MOD_HI, 16'h0009);
    w16(`TPC_OFF_CH_BASE + 8'h01, 16'h0004);
    wr(`TPC_OFF_CH_BASE, 8'h1A);
    wr(`TPC_OFF_STATUS, 8'h00);
    `CHK(pin_oe[0], 1'b1)
    scan();
    `CHK(r, 8'd3)
    `CHK(h, 8'd12)
    wr(`TPC_OFF_STATUS, 8'h20);
    `CHK(irq, 1'b0)
    wr(`TPC_OFF_STATUS, 8'h60);
    `CHK(irq, 1'b1)
    wr(`TPC_OFF_STATUS, 8'h20);
    `CHK(irq, 1'b0)
    rdc(`TPC_OFF_STATUS, 8'hA0);
    brk <= 1'b1;
    wr(`TPC_OFF_STATUS, 8'h20);
    rdc(`TPC_OFF_STATUS, 8'hA0);
    brk <= 1'b0;
    wr(`TPC_OFF_STATUS, 8'h20);
    rdc(`TPC_OFF_STATUS, 8'h20);
    wr(`TPC_OFF_STATUS, 8'h00);
    wr(`TPC_OFF_CH_BASE, 8'h5A);
    repeat (12) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(`TPC_OFF_CH_BASE, 8'h1A);
    `CHK(irq, 1'b0)
    wr(`TPC_OFF_CH_BASE, 8'h1E);
    scan();
    `CHK(h, 8'd18)
    wr(`TPC_OFF_CH_BASE, 8'h18);
    scan();
    `CHK(h + r, 8'd0)
    wr(`TPC_OFF_CH_BASE, 8'h19);
    scan();
    `CHK(h, 8'd30)
    wr(`TPC_OFF_CH_BASE, 8'h3A);
    scan();
    `CHK(h, 8'd12)
    w16(`TPC_OFF_CH_BASE + 8'h04, 16'h0002);
    scan();
    `CHK(h, 8'd6)
    w16(`TPC_OFF_CH_BASE + 8'h01, 16'h0006);
    scan();
    `CHK(h, 8'd18)
    wr(`TPC_OFF_STATUS, 8'h20);
    bce <= 1'b1;
    brk <= 1'b1;
    rdc(`TPC_OFF_STATUS, 8'hA0);
    wr(`TPC_OFF_STATUS, 8'h20);
    brk <= 1'b0;
    bce <= 1'b0;
    rdc(`TPC_OFF_STATUS, 8'h20);
    complete_run();
  end
endmodule : tb_timer_pwm_channels

/* File: tpc_pin_model.sv */
// Purpose: Far side of the timer: clock source and channel pin wiring.
// Assumes: The clock pin is always an input of the timer.
// Notes:   The clock holds its level while not running.
`timescale 1ns/1ps

module tpc_pin_model (
  input wire logic clk_run, // Let the external clock run.
  input wire logic [5:0] far_level, // Level applied to undriven pins.
  input wire logic [5:0] ch_pin_out, // Timer compare outputs.
  input wire logic [5:0] ch_pin_oe, // Timer drive enables.
  output logic ext_timer_clock_pin, // External counter clock.
  output logic [5:0] ch_pin_in // Resolved pin levels.
);
  // ==========================================================================
  // Clock source
  // Runs at 4 MHz, far below the 125 MHz bus clock that samples it.
  initial ext_timer_clock_pin = 1'b0;
  always begin
    #125;
    if (clk_run) begin
      ext_timer_clock_pin = !ext_timer_clock_pin;
    end
  end
  // ==========================================================================
  // Pin wires
  assign ch_pin_in = (ch_pin_oe & ch_pin_out) | (~ch_pin_oe & far_level);
endmodule : tpc_pin_model

/* File: tpc_pkg.sv */
// Purpose: Shared types for the timer.
// Assumes: Nothing.
// Notes:   Constants live in tpc_regs.svh.
package tpc_pkg;
  typedef logic [15:0] tpc_word_t;
  typedef logic [7:0] tpc_byte_t;
endpackage : tpc_pkg

/* File: tpc_regs.svh */
// Purpose: Register offsets, field positions and reset values for the timer.
// Assumes: Byte-wide registers on a plain strobe port, 8-bit addresses.
// Notes:   Offsets are local indices; all values in one place.
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// ==========================================================================
// Offsets
`define TPC_OFF_STATUS   8'h00
`define TPC_OFF_CNT_HI   8'h01
`define TPC_OFF_CNT_LO   8'h02
`define TPC_OFF_MOD_HI   8'h03
`define TPC_OFF_MOD_LO   8'h04
`define TPC_OFF_BRK_CTL  8'h05
// Channel n: control at 8'h10+3n, value high +1, value low +2.
`define TPC_OFF_CH_BASE  8'h10

// ==========================================================================
// Status and control fields
`define TPC_ST_OVF       7
`define TPC_ST_OVF_IE    6
`define TPC_ST_HALT      5
`define TPC_ST_CLR       4
`define TPC_ST_PS_HI     2
`define TPC_ST_RESET     8'h20

// ==========================================================================
// Channel control fields
`define TPC_CH_FLAG      7
`define TPC_CH_IE        6
`define TPC_CH_BUF       5
`define TPC_CH_UNBUF     4
`define TPC_CH_ELS_HI    3
`define TPC_CH_ELS_LO    2
`define TPC_CH_TOV       1
`define TPC_CH_MAX       0

`define TPC_MOD_RESET    16'hFFFF
`define TPC_PS_EXT       3'h7

`endif

/* File: tpc_timer.sv */
// Purpose: Six-channel 16-bit timer with modulo, PWM and buffered pairs.
// Assumes: Byte register port; channel and clock pins are asynchronous.
// Notes:   Reads in wait mode return zero and writes are dropped.
// Notes on behaviour
// - Mode code 01 unbuffered, 10 buffered.
// - Compare action 10 clears, 11 sets output.
// - Even buffered bit links pair, overrides unbuffered.
// - Toggle-on-overflow clear means no overflow toggle.
// - Full-duty with no toggle holds output high.
// - Overflow flag on wrap; interrupt when enabled.
// - Channel flag on event; interrupt when enabled.
// - Wait mode runs on, blocks access, wakes.
// - Stop mode freezes counter, prescaler, flags and outputs; pin synchronizers keep sampling.
// - Break halts counter and blocks captures.
// - Break protects flags unless clear enable set.
// - External clock pin forced to input when prescale is 111.
// - Overflow flag clears by read then zero write.
// - Overflow interrupt enable resets to zero.
// - Halt freezes counter, reset sets, blocks captures.
// - Clear bit zeroes counter and prescaler, self-clears.
// - Halt plus clear leaves counter at zero.
// - Prescale 000..110 divides, 111 external pin.
// - Buffered pair swaps to last written at overflow.
// - Period is overflow spacing, width overflow-to-compare.
// - Count wraps to zero after modulo match.
`timescale 1ns/1ps
`include "tpc_regs.svh"

module tpc_timer #(
  parameter int NCH = 6
) (
  input wire logic clk, // Bus clock, 125 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [7:0] addr, // Register address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic wr_en, // Write strobe.
  input wire logic rd_en, // Read strobe.
  output tpc_pkg::tpc_byte_t rdata, // Read data, cycle after strobe.
  input wire logic wait_mode, // System in wait mode.
  input wire logic stop_mode, // System in stop mode.
  input wire logic break_active, // Break state active.
  input wire logic break_clear_enable, // Flags clearable in break.
  input wire logic ext_timer_clock_pin, // External counter clock pin.
  output logic ext_clk_pin_force_in, // Pin forced to input.
  input wire logic [5:0] ch_pin_in, // Channel pins, capture side.
  output logic [5:0] ch_pin_out, // Channel compare outputs.
  output logic [5:0] ch_pin_oe, // Channel pin drive enables.
  output logic irq // Timer interrupt request.
);

  // ========================================================================
  // Register state
  tpc_pkg::tpc_word_t cnt_reg;
  tpc_pkg::tpc_word_t mod_reg;
  logic [6:0] pre_reg;
  logic overflow_flag_reg;
  logic overflow_irq_enable_reg;
  logic counter_halt_reg;
  logic [2:0] prescale_select_reg;
  logic ovf_armed_reg;
  logic mod_lock_reg;
  tpc_pkg::tpc_byte_t mod_hi_buf_reg;
  tpc_pkg::tpc_byte_t ctl_reg [NCH];
  tpc_pkg::tpc_word_t val_reg [NCH];
  tpc_pkg::tpc_byte_t val_hi_buf_reg [NCH];
  logic [NCH-1:0] flag_armed_reg;
  logic [NCH-1:0] out_reg;
  logic [2:0] sel_reg; // Pair uses odd set when set.
  logic [2:0] pend_reg; // Pair's next set after overflow.
  logic [2:0] ext_sync_reg;
  logic [NCH-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;

  // ========================================================================
  // Decode helpers
  function automatic logic is_ch_addr(input logic [7:0] a);
    is_ch_addr = (a >= `TPC_OFF_CH_BASE) &&
                 (a < `TPC_OFF_CH_BASE + 8'(3 * NCH));
  endfunction : is_ch_addr

  function automatic logic [2:0] ch_idx(input logic [7:0] a);
    ch_idx = 3'((a - `TPC_OFF_CH_BASE) / 8'd3);
  endfunction : ch_idx

  function automatic logic [1:0] ch_sub(input logic [7:0] a);
    ch_sub = 2'((a - `TPC_OFF_CH_BASE) % 8'd3);
  endfunction : ch_sub

  // Wait mode makes the registers unreachable; stop also blocks them and freezes counting.
  logic acc_ok, wr, rd, in_brk_lock;
  assign acc_ok = !wait_mode && !stop_mode;
  assign wr = wr_en && acc_ok;
  assign rd = rd_en && acc_ok;
  assign in_brk_lock = break_active && !break_clear_enable;

  // ========================================================================
  // Prescaler and counter tick
  logic ext_rise, div_tick, tick, run, clr_cnt, ovf_evt;
  tpc_pkg::tpc_word_t cnt_next;
  assign ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
  assign ext_clk_pin_force_in =
    (prescale_select_reg == `TPC_PS_EXT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_sync_reg <= 3'h0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_timer_clock_pin};
      pin_s1_reg <= ch_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Divide by 2^code: tick when low code bits of the prescaler are all ones.
  always_comb begin
    div_tick = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(prescale_select_reg) && !pre_reg[i]) begin
        div_tick = 1'b0;
      end
    end
  end

  assign run = !counter_halt_reg && !break_active &&
               !stop_mode;
  assign tick = run && ((prescale_select_reg == `TPC_PS_EXT) ?
                ext_rise : div_tick);
  assign clr_cnt = wr && (addr == `TPC_OFF_STATUS) &&
                   wdata[`TPC_ST_CLR];
  assign ovf_evt = tick && (cnt_reg == mod_reg) && !mod_lock_reg;
  // Compares look at the value the counter moves to, so a width of N keeps
  // the pulse for exactly N counts after overflow, not N plus one.
  assign cnt_next = (cnt_reg == mod_reg) ? 16'h0000 : cnt_reg + 16'h0001;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_reg <= 7'h00;
    end else if (clr_cnt) begin
      pre_reg <= 7'h00;
    end else if (run) begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  // Wrap to zero on the tick after a modulo match.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
    end else if (clr_cnt) begin
      cnt_reg <= 16'h0000;
    end else if (tick) begin
      cnt_reg <= cnt_next;
    end
  end

  // ========================================================================
  // Status register: halt, enable, prescale, overflow flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_halt_reg <= 1'b1;
      overflow_irq_enable_reg <= 1'b0;
      prescale_select_reg <= 3'h0;
    end else if (wr && addr == `TPC_OFF_STATUS) begin
      counter_halt_reg <= wdata[`TPC_ST_HALT];
      overflow_irq_enable_reg <= wdata[`TPC_ST_OVF_IE];
      prescale_select_reg <= wdata[`TPC_ST_PS_HI:0];
    end
  end

  // A new overflow re-arms nothing and wins over a pending clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overflow_flag_reg <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag_reg <= 1'b1;
      ovf_armed_reg <= 1'b0;
    end else if (!in_brk_lock) begin
      if (rd && addr == `TPC_OFF_STATUS && overflow_flag_reg) begin
        ovf_armed_reg <= 1'b1;
      end else if (wr && addr == `TPC_OFF_STATUS) begin
        if (ovf_armed_reg && !wdata[`TPC_ST_OVF]) begin
          overflow_flag_reg <= 1'b0;
        end
        ovf_armed_reg <= 1'b0;
      end
    end
  end

  // Writing the high half holds off overflow until the low half lands.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mod_reg <= `TPC_MOD_RESET;
      mod_hi_buf_reg <= 8'h00;
      mod_lock_reg <= 1'b0;
    end else if (wr && addr == `TPC_OFF_MOD_HI) begin
      mod_hi_buf_reg <= wdata;
      mod_lock_reg <= 1'b1;
    end else if (wr && addr == `TPC_OFF_MOD_LO) begin
      mod_reg <= {mod_hi_buf_reg, wdata};
      mod_lock_reg <= 1'b0;
    end
  end

  // ========================================================================
  // Channels
  logic [NCH-1:0] cmp_hit, cap_evt, is_out, pair_lead, pair_tail;
  logic [NCH-1:0] ch_evt;
  logic [2:0] wi;
  logic [1:0] ws;
  assign wi = ch_idx(addr);
  assign ws = ch_sub(addr);

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      automatic int p = c / 2;
      automatic logic [2:0] lead = 3'(c & ~1);
      automatic logic buf_pair = ctl_reg[lead][`TPC_CH_BUF];
      automatic tpc_pkg::tpc_word_t v;
      pair_lead[c] = (c % 2 == 0) && ctl_reg[c][`TPC_CH_BUF];
      pair_tail[c] = (c % 2 == 1) && buf_pair;
      // Buffered bit takes priority over the unbuffered bit.
      is_out[c] = pair_lead[c] ||
                  (!pair_tail[c] && ctl_reg[c][`TPC_CH_UNBUF]);
      v = (pair_lead[c] && sel_reg[p]) ? val_reg[c | 1] : val_reg[c];
      cmp_hit[c] = tick && is_out[c] && (cnt_next == v);
      // Captures need at least one edge bit set and a running counter.
      cap_evt[c] = run && !is_out[c] && !pair_tail[c] &&
        (ctl_reg[c][`TPC_CH_ELS_HI] | ctl_reg[c][`TPC_CH_ELS_LO]) &&
        ((ctl_reg[c][`TPC_CH_ELS_LO] && pin_s2_reg[c] && !pin_s3_reg[c]) ||
         (ctl_reg[c][`TPC_CH_ELS_HI] && !pin_s2_reg[c] && pin_s3_reg[c]));
      ch_evt[c] = cmp_hit[c] || cap_evt[c];
    end
  end

  // Channel control, values, flags and capture loads.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        ctl_reg[c] <= 8'h00;
        val_reg[c] <= 16'h0000;
        val_hi_buf_reg[c] <= 8'h00;
      end
      flag_armed_reg <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (cap_evt[c]) begin
          val_reg[c] <= cnt_reg;
        end
        if (ch_evt[c]) begin
          ctl_reg[c][`TPC_CH_FLAG] <= 1'b1;
          flag_armed_reg[c] <= 1'b0;
        end else if (!in_brk_lock && is_ch_addr(addr) && wi == 3'(c) &&
                     ws == 2'd0) begin
          if (rd && ctl_reg[c][`TPC_CH_FLAG]) begin
            flag_armed_reg[c] <= 1'b1;
          end else if (wr) begin
            if (flag_armed_reg[c] && !wdata[`TPC_CH_FLAG]) begin
              ctl_reg[c][`TPC_CH_FLAG] <= 1'b0;
            end
            flag_armed_reg[c] <= 1'b0;
          end
        end
        if (wr && is_ch_addr(addr) && wi == 3'(c)) begin
          if (ws == 2'd0) begin
            ctl_reg[c][6:0] <= wdata[6:0];
          end else if (ws == 2'd1) begin
            val_hi_buf_reg[c] <= wdata;
          end else begin
            val_reg[c] <= {val_hi_buf_reg[c], wdata};
          end
        end
      end
    end
  end

  // Buffered pairs: last written set takes over at overflow.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_reg <= 3'h0;
      pend_reg <= 3'h0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (!ctl_reg[2*p][`TPC_CH_BUF]) begin
          sel_reg[p] <= 1'b0;
          pend_reg[p] <= 1'b0;
        end else begin
          if (wr && is_ch_addr(addr) && ws == 2'd2 && wi[2:1] == 2'(p)) begin
            pend_reg[p] <= wi[0];
          end
          if (ovf_evt) begin
            sel_reg[p] <= pend_reg[p];
          end
        end
      end
    end
  end

  // Output: compare sets or clears, then overflow toggle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_reg <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (is_out[c]) begin
          if (ctl_reg[c][`TPC_CH_MAX] && !ctl_reg[c][`TPC_CH_TOV]) begin
            out_reg[c] <= 1'b1;
          end else if (cmp_hit[c] && ctl_reg[c][`TPC_CH_ELS_HI]) begin
            out_reg[c] <= ctl_reg[c][`TPC_CH_ELS_LO];
          end else if (cmp_hit[c] && ctl_reg[c][`TPC_CH_ELS_LO]) begin
            out_reg[c] <= !out_reg[c]; // Toggle on compare.
          end else if (ovf_evt && ctl_reg[c][`TPC_CH_TOV]) begin
            out_reg[c] <= !out_reg[c];
          end
        end
      end
    end
  end

  assign ch_pin_out = out_reg;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ch_pin_oe[c] = is_out[c] &&
        (ctl_reg[c][`TPC_CH_ELS_HI] | ctl_reg[c][`TPC_CH_ELS_LO]);
    end
  end

  // ========================================================================
  // Interrupt request, live in wait mode to wake the system.
  always_comb begin
    irq = overflow_flag_reg && overflow_irq_enable_reg;
    for (int c = 0; c < NCH; c++) begin
      if (ctl_reg[c][`TPC_CH_FLAG] && ctl_reg[c][`TPC_CH_IE]) begin
        irq = 1'b1;
      end
    end
  end

  // ========================================================================
  // Read port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (!rd) begin
      rdata <= 8'h00;
    end else if (addr == `TPC_OFF_STATUS) begin
      rdata <= {overflow_flag_reg, overflow_irq_enable_reg,
                counter_halt_reg, 1'b0, 1'b0, prescale_select_reg};
    end else if (addr == `TPC_OFF_CNT_HI) begin
      rdata <= cnt_reg[15:8];
    end else if (addr == `TPC_OFF_CNT_LO) begin
      rdata <= cnt_reg[7:0];
    end else if (addr == `TPC_OFF_MOD_HI) begin
      rdata <= mod_reg[15:8];
    end else if (addr == `TPC_OFF_MOD_LO) begin
      rdata <= mod_reg[7:0];
    end else if (is_ch_addr(addr)) begin
      rdata <= (ws == 2'd0) ? ctl_reg[wi] :
               (ws == 2'd1) ? val_reg[wi][15:8] : val_reg[wi][7:0];
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : tpc_timer

/* File: tpc_timer_checker.sv */
// Purpose: Port-level assertions for the six-channel timer.
// Assumes: Status and enables change only by bus writes outside wait/stop.
// Notes:   Shadows of the status fields are rebuilt from the write stream.
`timescale 1ns/1ps
`include "tpc_regs.svh"

module tpc_timer_checker (
  input wire logic clk, // Bus clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [7:0] addr, // Register address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic wr_en, // Write strobe.
  input wire logic rd_en, // Read strobe.
  input wire tpc_pkg::tpc_byte_t rdata, // Read data.
  input wire logic wait_mode, // Wait mode.
  input wire logic stop_mode, // Stop mode.
  input wire logic break_active, // Break state.
  input wire logic break_clear_enable, // Flag clear in break.
  input wire logic ext_timer_clock_pin, // External clock pin.
  input wire logic ext_clk_pin_force_in, // Pin forced to input.
  input wire logic [5:0] ch_pin_in, // Channel pin levels.
  input wire logic [5:0] ch_pin_out, // Channel outputs.
  input wire logic [5:0] ch_pin_oe, // Channel drive enables.
  input wire logic irq // Interrupt request.
);
  // ==========================================================================
  // Shadow state
  logic [7:0] st_reg;
  logic [6:0] ie_reg;
  logic fz_reg;
  logic acc;
  assign acc = !wait_mode && !stop_mode;
  // The counter is known to sit at zero from reset or halt plus clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= `TPC_ST_RESET;
      fz_reg <= 1'b1;
    end else if (wr_en && acc && addr == `TPC_OFF_STATUS) begin
      st_reg <= {1'b0, wdata[6:5], 2'b00, wdata[2:0]};
      fz_reg <= wdata[5] && (wdata[4] || fz_reg);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ie_reg <= 7'h00;
    end else if (wr_en && acc) begin
      if (addr == `TPC_OFF_STATUS) begin
        ie_reg[6] <= wdata[6];
      end
      for (int n = 0; n < 6; n++) begin
        if (addr == `TPC_OFF_CH_BASE + 8'(3 * n)) begin
          ie_reg[n] <= wdata[6];
        end
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Assertions
  clr_reads_zero_a: assert property (
    $past(rd_en && acc && addr == `TPC_OFF_STATUS) |-> !rdata[4])
    else $error("Clear bit read back as one.");
  wait_blocks_read_a: assert property (
    $past(rd_en && wait_mode) |-> rdata == 8'h00)
    else $error("Register read in wait mode returned data.");
  stop_freezes_pins_a: assert property (
    stop_mode && $past(stop_mode) |-> $stable(ch_pin_out))
    else $error("Channel output moved in stop mode.");
  irq_needs_enable_a: assert property (
    irq |-> |ie_reg)
    else $error("Interrupt raised with every enable clear.");
  irq_after_reset_a: assert property (
    !$past(rst_n) |-> !irq)
    else $error("Interrupt raised just after reset.");
  ctl_bits_read_a: assert property (
    $past(rd_en && acc && addr == `TPC_OFF_STATUS)
    |-> rdata[6:5] == $past(st_reg[6:5]))
    else $error("Enable or halt bit read back wrong.");
  ps_read_a: assert property (
    $past(rd_en && acc && addr == `TPC_OFF_STATUS)
    |-> rdata[2:0] == $past(st_reg[2:0]))
    else $error("Prescale field read back wrong.");
  ext_pin_input_a: assert property (
    ext_clk_pin_force_in == (st_reg[2:0] == `TPC_PS_EXT))
    else $error("Clock pin input forcing does not follow prescale.");
  halt_clear_zero_a: assert property (
    $past(rd_en && acc && fz_reg
    && (addr == `TPC_OFF_CNT_HI || addr == `TPC_OFF_CNT_LO))
    |-> rdata == 8'h00)
    else $error("Halted and cleared counter read nonzero.");
  irq_seen_c: cover property (irq);
  ext_sel_c: cover property ($rose(ext_clk_pin_force_in));
  stop_held_c: cover property (stop_mode && $past(stop_mode));
endmodule : tpc_timer_checker

bind tpc_timer tpc_timer_checker u_chk (.clk, .rst_n, .addr, .wdata,
  .wr_en, .rd_en, .rdata, .wait_mode, .stop_mode, .break_active,
  .break_clear_enable, .ext_timer_clock_pin, .ext_clk_pin_force_in,
  .ch_pin_in, .ch_pin_out, .ch_pin_oe, .irq);
